// file: logic/dqp_pkg.sv
// Shared constants for the port QoS classifier and policer
package dqp_pkg;

  // Clock and policer refill tick
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 200000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  // One rate unit is 40000 bps, which is one byte per tick
  localparam int RATE_UNIT_BPS = 40000;
  localparam logic [19:0] CIR_MIN_UNITS = 20'h0_0001;
  localparam logic [19:0] CIR_MAX_UNITS = 20'h1_86A0;
  localparam logic [19:0] EIR_MAX_UNITS = 20'hF_4240;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_CTRLCNT = 12'h008;
  localparam logic [11:0] OFF_CONFORM = 12'h00C;
  localparam logic [11:0] OFF_EXCEED = 12'h010;
  localparam logic [11:0] OFF_POL = 12'h020;
  localparam logic [11:0] OFF_PGT = 12'h040;
  localparam logic [11:0] OFF_PMAP = 12'h080;
  localparam logic [11:0] OFF_DSCP = 12'h100;

  // Control register fields
  localparam int CTL_FABRIC = 0;
  localparam int CTL_ADAPTER = 1;
  localparam int CTL_APPLY_MAP = 2;
  localparam int CTL_APPLY_DSCP = 3;
  localparam int CTL_FPRIO = 4;
  localparam int CTL_LPRIO = 8;
  localparam int CTL_LTC = 12;

  // Status register fields
  localparam int ST_MAP_ERR = 0;
  localparam int ST_DSCP_ERR = 1;
  localparam int ST_TRUST = 2;
  localparam int ST_MAP_OK = 3;

  // Action register fields
  localparam int ACT_TC = 0;
  localparam int ACT_PRIO = 3;
  localparam int ACT_DSCP = 6;
  localparam int ACT_PREC = 12;
  localparam int ACT_EN_TC = 16;
  localparam int ACT_EN_PRIO = 17;
  localparam int ACT_EN_DSCP = 18;
  localparam int ACT_EN_PREC = 19;

  // Group table entry fields
  localparam int PG_PFC = 8;
  localparam int PG_ROW = 12;
  localparam int PG_STRICT = 16;

  // Reset values, reserved fabric priority and control frame queue
  localparam logic [2:0] FABRIC_PRIO_RST = 3'h0;
  localparam logic [2:0] LOSSLESS_RST = 3'h3;
  localparam logic [15:0] PFC_RST = 16'h0201;
  localparam logic [2:0] FABRIC_RESERVED = 3'h7;
  localparam logic [2:0] CTRL_QUEUE = 3'h7;

  typedef enum logic [1:0] {
    COL_GREEN = 2'b00,
    COL_YELLOW = 2'b01,
    COL_RED = 2'b10
  } dqp_color_t;

endpackage : dqp_pkg

// file: logic/dqp_dscp_mem.sv
// DSCP classification memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module dqp_dscp_mem #(
  parameter int W = 6,
  parameter int D = 64
) (
  input wire logic core_clk,
  input wire logic wrEn,
  input wire logic [$clog2(D)-1:0] wrAddr,
  input wire logic [W-1:0] wrData,
  input wire logic rdEn,
  input wire logic [$clog2(D)-1:0] rdAddr,
  output logic [W-1:0] rdData
);
  if (W < 1 || D < 2) begin : gBadSize
    $error("dqp_dscp_mem: bad size");
  end

  logic [W-1:0] mem [D];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : dqp_dscp_mem
`default_nettype wire

// file: logic/dqp_qos.sv
// Port QoS: group table, priority map, fabric remap, DSCP trust, two-rate policer
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Sixteen group rows, share and flow-control flag
// - Rows 15.x strict, rows 0-7 weighted
// - Rank follows row order, 15.0 highest
// - Reset flow control on 15.0, 1; zero shares
// - Flow-control group takes one priority, TC=priority
// - Violating map flags error, restores group defaults
// - Adapter-facing port allows one strict group
// - Priority map selects group and flow control
// - Fabric mode remaps tagged priority 7
// - Fabric untagged control frames counted in queue 7
// - Fabric mode: trust off, no default maps
// - Fabric DSCP class never 7 or lossless
// - Fabric DSCP priority never 7 or lossless
// - Refuse DSCP apply with reserved entries, error
// - Valid applied DSCP maps enable trust
// - Police inbound and outbound with two-rate marker
// - One-rate: conform or violate, violate dropped
// - Two-rate: conform, exceed actions, violate dropped
// - Actions rewrite precedence, priority, DSCP, class
// - Green within committed rate, 40k-4G bps
// - Yellow within excess rate, up to 40G
// - Red frames always dropped
// - Unused committed credit accumulates to burst size
// - No excess rate or burst: green/red only
module dqp_qos (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frmValid,
  input wire logic frmTagged,
  input wire logic frmCtrl,
  input wire logic frmEgress,
  input wire logic [2:0] frmPrio,
  input wire logic [5:0] frmDscp,
  input wire logic [15:0] frmLen,
  output logic outValid,
  output logic outDrop,
  output logic [1:0] outColor,
  output logic [2:0] outPrio,
  output logic [5:0] outDscp,
  output logic [2:0] outTc,
  output logic [3:0] outGroup,
  output logic outStrict,
  output logic outPfc,
  output logic [7:0] pfcPrioMask
);
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  function automatic logic [31:0] minSat(input logic [32:0] v, input logic [31:0] cap);
    minSat = (v > {1'b0, cap}) ? cap : v[31:0];
  endfunction : minSat

  // Bus access qualifiers
  logic wrAcc;
  logic rdSetup;
  assign wrAcc = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign pready = 1'b1;

  // Configuration state
  logic fabric_ff, adapter_ff;
  logic [2:0] fPrio_ff, lPrio_ff, lTc_ff;
  logic mapErr_ff, dscpErr_ff, trust_ff, mapOk_ff, dscpWritten_ff;
  logic [7:0] bw_ff [16];
  logic [15:0] pfc_ff;
  logic [3:0] pmap_ff [8];
  logic [19:0] cir_ff [2];
  logic [19:0] eir_ff [2];
  logic [31:0] cbs_ff [2];
  logic [31:0] ebs_ff [2];
  logic [19:0] confAct_ff, excAct_ff;
  logic [31:0] ctrlCnt_ff;
  logic [63:0] dscpBad_ff;
  logic applyMap, applyDscp;

  assign applyMap = wrAcc && hit(paddr, dqp_pkg::OFF_CTRL) && pwdata[dqp_pkg::CTL_APPLY_MAP];
  assign applyDscp = wrAcc && hit(paddr, dqp_pkg::OFF_CTRL) && pwdata[dqp_pkg::CTL_APPLY_DSCP];

  // Map checks over the priority table
  logic pfcViol, spViol;
  logic [15:0] used;
  always_comb begin
    pfcViol = 1'b0;
    used = 16'h0000;
    for (int p = 0; p < 8; p++) begin
      used[pmap_ff[p]] = 1'b1;
      for (int q = 0; q < 8; q++) begin
        if (q != p && pfc_ff[pmap_ff[p]] && pmap_ff[q] == pmap_ff[p]) begin
          pfcViol = 1'b1;
        end
      end
    end
    spViol = adapter_ff && ($countones(used[7:0]) > 1);
  end

  logic mapBad;
  assign mapBad = pfcViol || spViol;

  // DSCP entry validity against reserved priorities
  logic [5:0] dscpWr;
  logic dscpWe;
  logic entryBad;
  assign dscpWe = wrAcc && (paddr[11:8] == dqp_pkg::OFF_DSCP[11:8]);
  assign dscpWr = pwdata[5:0];
  assign entryBad = (dscpWr[2:0] == 3'h7) || (dscpWr[2:0] == lTc_ff) ||
                    (dscpWr[5:3] == 3'h7) || (dscpWr[5:3] == lPrio_ff);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fabric_ff <= 1'b0;
      adapter_ff <= 1'b0;
      fPrio_ff <= dqp_pkg::FABRIC_PRIO_RST;
      lPrio_ff <= dqp_pkg::LOSSLESS_RST;
      lTc_ff <= dqp_pkg::LOSSLESS_RST;
    end else if (wrAcc && hit(paddr, dqp_pkg::OFF_CTRL)) begin
      fabric_ff <= pwdata[dqp_pkg::CTL_FABRIC];
      adapter_ff <= pwdata[dqp_pkg::CTL_ADAPTER];
      fPrio_ff <= pwdata[dqp_pkg::CTL_FPRIO +: 3];
      lPrio_ff <= pwdata[dqp_pkg::CTL_LPRIO +: 3];
      lTc_ff <= pwdata[dqp_pkg::CTL_LTC +: 3];
    end
  end

  // Group table and priority map
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pfc_ff <= dqp_pkg::PFC_RST;
      for (int i = 0; i < 16; i++) begin
        bw_ff[i] <= 8'h00;
      end
    end else if (applyMap && mapBad) begin
      pfc_ff <= dqp_pkg::PFC_RST;
      for (int i = 0; i < 16; i++) begin
        bw_ff[i] <= 8'h00;
      end
    end else if (wrAcc && paddr[11:6] == dqp_pkg::OFF_PGT[11:6]) begin
      pfc_ff[paddr[5:2]] <= pwdata[dqp_pkg::PG_PFC];
      if (paddr[5]) begin
        bw_ff[paddr[5:2]] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < 8; p++) begin
        pmap_ff[p] <= 4'h8 + 4'(p);
      end
    end else if (wrAcc && paddr[11:5] == dqp_pkg::OFF_PMAP[11:5]) begin
      pmap_ff[paddr[4:2]] <= pwdata[3:0];
    end
  end

  // Status: hardware set wins over software clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mapErr_ff <= 1'b0;
      mapOk_ff <= 1'b0;
      dscpErr_ff <= 1'b0;
      trust_ff <= 1'b0;
    end else begin
      if (applyMap && mapBad) begin
        mapErr_ff <= 1'b1;
        mapOk_ff <= 1'b0;
      end else begin
        if (wrAcc && hit(paddr, dqp_pkg::OFF_STATUS) && pwdata[dqp_pkg::ST_MAP_ERR]) begin
          mapErr_ff <= 1'b0;
        end
        if (applyMap) begin
          mapOk_ff <= 1'b1;
        end
      end
      if (applyDscp && (|dscpBad_ff || !dscpWritten_ff)) begin
        dscpErr_ff <= 1'b1;
        trust_ff <= 1'b0;
      end else begin
        if (wrAcc && hit(paddr, dqp_pkg::OFF_STATUS) && pwdata[dqp_pkg::ST_DSCP_ERR]) begin
          dscpErr_ff <= 1'b0;
        end
        if (applyDscp) begin
          trust_ff <= 1'b1;
        end else if (wrAcc && hit(paddr, dqp_pkg::OFF_CTRL) &&
                     pwdata[dqp_pkg::CTL_FABRIC] && !fabric_ff) begin
          trust_ff <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dscpBad_ff <= 64'h0000_0000_0000_0000;
      dscpWritten_ff <= 1'b0;
    end else if (dscpWe) begin
      dscpBad_ff[paddr[7:2]] <= entryBad;
      dscpWritten_ff <= 1'b1;
    end
  end

  // Policer and action configuration
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      confAct_ff <= 20'h0_0000;
      excAct_ff <= 20'h0_0000;
      for (int d = 0; d < 2; d++) begin
        cir_ff[d] <= dqp_pkg::CIR_MIN_UNITS;
        eir_ff[d] <= 20'h0_0000;
        cbs_ff[d] <= 32'h0000_0000;
        ebs_ff[d] <= 32'h0000_0000;
      end
    end else if (wrAcc) begin
      if (hit(paddr, dqp_pkg::OFF_CONFORM)) begin
        confAct_ff <= pwdata[19:0];
      end
      if (hit(paddr, dqp_pkg::OFF_EXCEED)) begin
        excAct_ff <= pwdata[19:0];
      end
      if (paddr[11:5] == dqp_pkg::OFF_POL[11:5]) begin
        unique case (paddr[3:2])
          2'b00: cir_ff[paddr[4]] <= (pwdata > 32'(dqp_pkg::CIR_MAX_UNITS)) ?
              dqp_pkg::CIR_MAX_UNITS : (pwdata[19:0] < dqp_pkg::CIR_MIN_UNITS) ?
              dqp_pkg::CIR_MIN_UNITS : pwdata[19:0];
          2'b01: cbs_ff[paddr[4]] <= pwdata;
          2'b10: eir_ff[paddr[4]] <= (pwdata > 32'(dqp_pkg::EIR_MAX_UNITS)) ?
              dqp_pkg::EIR_MAX_UNITS : pwdata[19:0];
          2'b11: ebs_ff[paddr[4]] <= pwdata;
        endcase
      end
    end
  end

  // Read data captured in the setup phase
  logic [31:0] rdMux;
  logic rdMapped;
  always_comb begin
    rdMux = 32'h0000_0000;
    rdMapped = 1'b1;
    if (hit(paddr, dqp_pkg::OFF_CTRL)) begin
      rdMux = {17'h0_0000, lTc_ff, 1'b0, lPrio_ff, 1'b0, fPrio_ff, 2'b00, adapter_ff, fabric_ff};
    end else if (hit(paddr, dqp_pkg::OFF_STATUS)) begin
      rdMux = {28'h000_0000, mapOk_ff, trust_ff, dscpErr_ff, mapErr_ff};
    end else if (hit(paddr, dqp_pkg::OFF_CTRLCNT)) begin
      rdMux = ctrlCnt_ff;
    end else if (hit(paddr, dqp_pkg::OFF_CONFORM)) begin
      rdMux = {12'h000, confAct_ff};
    end else if (hit(paddr, dqp_pkg::OFF_EXCEED)) begin
      rdMux = {12'h000, excAct_ff};
    end else if (paddr[11:5] == dqp_pkg::OFF_POL[11:5]) begin
      unique case (paddr[3:2])
        2'b00: rdMux = {12'h000, cir_ff[paddr[4]]};
        2'b01: rdMux = cbs_ff[paddr[4]];
        2'b10: rdMux = {12'h000, eir_ff[paddr[4]]};
        2'b11: rdMux = ebs_ff[paddr[4]];
      endcase
    end else if (paddr[11:6] == dqp_pkg::OFF_PGT[11:6]) begin
      rdMux = {15'h0000, ~paddr[5], paddr[5:2], 3'h0, pfc_ff[paddr[5:2]],
               bw_ff[paddr[5:2]]};
    end else if (paddr[11:5] == dqp_pkg::OFF_PMAP[11:5]) begin
      rdMux = {28'h000_0000, pmap_ff[paddr[4:2]]};
    end else if (paddr[11:8] != dqp_pkg::OFF_DSCP[11:8]) begin
      rdMapped = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (rdSetup) begin
      prdata <= rdMux;
    end
  end
  assign pslverr = psel && penable && !rdMapped;

  // Frame stage 0: fabric remap and DSCP lookup launch
  logic s0Valid_ff, s0Ctrl_ff, s0Egress_ff;
  logic [2:0] s0Prio_ff;
  logic [5:0] s0Dscp_ff;
  logic [15:0] s0Len_ff;
  logic [5:0] memData;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s0Valid_ff <= 1'b0;
      s0Ctrl_ff <= 1'b0;
      s0Egress_ff <= 1'b0;
      s0Prio_ff <= 3'h0;
      s0Dscp_ff <= 6'h00;
      s0Len_ff <= 16'h0000;
    end else begin
      s0Valid_ff <= frmValid;
      if (frmValid) begin
        s0Ctrl_ff <= fabric_ff && !frmTagged && frmCtrl;
        s0Egress_ff <= frmEgress;
        s0Prio_ff <= (fabric_ff && frmTagged && frmPrio == dqp_pkg::FABRIC_RESERVED) ?
                     fPrio_ff : frmPrio;
        s0Dscp_ff <= frmDscp;
        s0Len_ff <= frmLen;
      end
    end
  end

  dqp_dscp_mem #(.W(6), .D(64)) uDscp (
    .core_clk(core_clk),
    .wrEn(dscpWe),
    .wrAddr(paddr[7:2]),
    .wrData(dscpWr),
    .rdEn(frmValid),
    .rdAddr(frmDscp),
    .rdData(memData)
  );

  // Refill tick
  logic [11:0] tickCnt_ff;
  logic tick;
  assign tick = (tickCnt_ff == 12'(dqp_pkg::TICK_CYC - 1));
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tickCnt_ff <= 12'h000;
    end else begin
      tickCnt_ff <= tick ? 12'h000 : tickCnt_ff + 12'h001;
    end
  end

  // Token buckets, one pair per direction
  logic [31:0] cLvl_ff [2];
  logic [31:0] eLvl_ff [2];
  logic [1:0] twoRate;
  logic [1:0] fits;
  logic [1:0] fitsE;
  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : gBkt
      logic fire;
      logic [31:0] cRef, eRef;
      assign twoRate[d] = (eir_ff[d] != 20'h0_0000) || (ebs_ff[d] != 32'h0000_0000);
      assign fits[d] = cLvl_ff[d] >= {16'h0000, s0Len_ff};
      assign fitsE[d] = twoRate[d] && (eLvl_ff[d] >= {16'h0000, s0Len_ff});
      assign fire = s0Valid_ff && !s0Ctrl_ff && (s0Egress_ff == 1'(d));
      assign cRef = tick ? minSat({1'b0, cLvl_ff[d]} + 33'(cir_ff[d]), cbs_ff[d]) :
                    minSat({1'b0, cLvl_ff[d]}, cbs_ff[d]);
      assign eRef = tick ? minSat({1'b0, eLvl_ff[d]} + 33'(eir_ff[d]), ebs_ff[d]) :
                    minSat({1'b0, eLvl_ff[d]}, ebs_ff[d]);
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          cLvl_ff[d] <= 32'h0000_0000;
          eLvl_ff[d] <= 32'h0000_0000;
        end else begin
          cLvl_ff[d] <= (fire && fits[d]) ? cRef - {16'h0000, s0Len_ff} : cRef;
          eLvl_ff[d] <= (fire && !fits[d] && fitsE[d]) ? eRef - {16'h0000, s0Len_ff} : eRef;
        end
      end
    end
  endgenerate

  // Frame stage 1: classification, color and actions
  dqp_pkg::dqp_color_t color;
  logic [2:0] nxtPrio, nxtTc;
  logic [5:0] nxtDscp;
  logic [19:0] act;
  always_comb begin
    nxtPrio = s0Prio_ff;
    nxtTc = s0Prio_ff;
    nxtDscp = s0Dscp_ff;
    if (trust_ff) begin
      nxtTc = memData[2:0];
      nxtPrio = memData[5:3];
    end
    if (s0Ctrl_ff) begin
      color = dqp_pkg::COL_GREEN;
      nxtTc = dqp_pkg::CTRL_QUEUE;
    end else if (fits[s0Egress_ff]) begin
      color = dqp_pkg::COL_GREEN;
    end else if (fitsE[s0Egress_ff]) begin
      color = dqp_pkg::COL_YELLOW;
    end else begin
      color = dqp_pkg::COL_RED;
    end
    act = (color == dqp_pkg::COL_YELLOW) ? excAct_ff : confAct_ff;
    if (!s0Ctrl_ff && color != dqp_pkg::COL_RED) begin
      if (act[dqp_pkg::ACT_EN_TC]) nxtTc = act[dqp_pkg::ACT_TC +: 3];
      if (act[dqp_pkg::ACT_EN_PRIO]) nxtPrio = act[dqp_pkg::ACT_PRIO +: 3];
      if (act[dqp_pkg::ACT_EN_DSCP]) nxtDscp = act[dqp_pkg::ACT_DSCP +: 6];
      if (act[dqp_pkg::ACT_EN_PREC]) nxtDscp[5:3] = act[dqp_pkg::ACT_PREC +: 3];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      outValid <= 1'b0;
      outDrop <= 1'b0;
      outColor <= dqp_pkg::COL_GREEN;
      outPrio <= 3'h0;
      outDscp <= 6'h00;
      outTc <= 3'h0;
      outGroup <= 4'h0;
      outStrict <= 1'b0;
      outPfc <= 1'b0;
    end else begin
      outValid <= s0Valid_ff;
      if (s0Valid_ff) begin
        outDrop <= (color == dqp_pkg::COL_RED);
        outColor <= color;
        outPrio <= nxtPrio;
        outDscp <= nxtDscp;
        outTc <= nxtTc;
        outGroup <= pmap_ff[nxtPrio];
        outStrict <= !pmap_ff[nxtPrio][3];
        outPfc <= pfc_ff[pmap_ff[nxtPrio]];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrlCnt_ff <= 32'h0000_0000;
      pfcPrioMask <= 8'h00;
    end else begin
      if (s0Valid_ff && s0Ctrl_ff) begin
        ctrlCnt_ff <= ctrlCnt_ff + 32'h0000_0001;
      end
      for (int p = 0; p < 8; p++) begin
        pfcPrioMask[p] <= pfc_ff[pmap_ff[p]];
      end
    end
  end

  // Checks
  sequence s_fabricTop;
    frmValid && fabric_ff && frmTagged && frmPrio == 3'h7;
  endsequence
  sequence s_ctrlIn;
    frmValid && fabric_ff && !frmTagged && frmCtrl;
  endsequence
  property p_remap;
    @(posedge core_clk) disable iff (!nrst) s_fabricTop |=> s0Prio_ff == $past(fPrio_ff);
  endproperty
  a_remap: assert property (p_remap) else $error("priority 7 not remapped");
  property p_ctrlQ;
    @(posedge core_clk) disable iff (!nrst) s_ctrlIn |-> ##2 outValid && outTc == 3'h7 && !outDrop;
  endproperty
  a_ctrlQ: assert property (p_ctrlQ) else $error("control frame not in queue 7");
  property p_ctrlCnt;
    @(posedge core_clk) disable iff (!nrst)
      s_ctrlIn |-> ##1 1'b1 ##1 ctrlCnt_ff == $past(ctrlCnt_ff) + 32'h0000_0001;
  endproperty
  a_ctrlCnt: assert property (p_ctrlCnt) else $error("control count missed");
  property p_redDrop;
    @(posedge core_clk) disable iff (!nrst) outValid && outColor == 2'b10 |-> outDrop;
  endproperty
  a_redDrop: assert property (p_redDrop) else $error("red frame passed");
  property p_oneRate;
    @(posedge core_clk) disable iff (!nrst) s0Valid_ff && !twoRate[s0Egress_ff] |=> outColor != 2'b01;
  endproperty
  a_oneRate: assert property (p_oneRate) else $error("yellow in one-rate mode");
  property p_mapRestore;
    @(posedge core_clk) disable iff (!nrst) applyMap && mapBad |=> pfc_ff == 16'h0201 && mapErr_ff;
  endproperty
  a_mapRestore: assert property (p_mapRestore) else $error("bad map not restored");
  property p_dscpRefuse;
    @(posedge core_clk) disable iff (!nrst) applyDscp && |dscpBad_ff |=> !trust_ff && dscpErr_ff;
  endproperty
  a_dscpRefuse: assert property (p_dscpRefuse) else $error("reserved DSCP map applied");
  property p_bucketCap;
    @(posedge core_clk) disable iff (!nrst) ##1 cLvl_ff[0] <= $past(cbs_ff[0]);
  endproperty
  a_bucketCap: assert property (p_bucketCap) else $error("bucket above burst size");
  property p_pfcMask;
    @(posedge core_clk) disable iff (!nrst)
      $stable(pfc_ff) && $stable(pmap_ff[1]) |=> pfcPrioMask[1] == $past(pfc_ff[pmap_ff[1]]);
  endproperty
  a_pfcMask: assert property (p_pfcMask) else $error("flow-control mask wrong");
endmodule : dqp_qos
`default_nettype wire

// file: verif/dqp_link_partner.sv
// Link partner model that hands frame descriptors to the port
`timescale 1ns/10ps
`default_nettype none
module dqp_link_partner (
  input wire logic core_clk,
  output logic frmValid,
  output logic frmTagged,
  output logic frmCtrl,
  output logic frmEgress,
  output logic [2:0] frmPrio,
  output logic [5:0] frmDscp,
  output logic [15:0] frmLen
);
  initial begin
    frmValid = 1'b0;
    {frmTagged, frmCtrl, frmEgress, frmPrio, frmDscp, frmLen} = '0;
  end

  // One descriptor per call; fields are scrambled once it is taken
  task automatic send(input logic [2:0] k, input logic [2:0] p, input logic [5:0] d,
      input logic [15:0] n);
    @(posedge core_clk);
    frmValid <= 1'b1;
    {frmTagged, frmCtrl, frmEgress} <= k;
    frmPrio <= p;
    frmDscp <= d;
    frmLen <= n;
    @(posedge core_clk);
    frmValid <= 1'b0;
    {frmTagged, frmCtrl, frmEgress, frmPrio, frmDscp, frmLen} <= ~{k, p, d, n};
  endtask : send
endmodule : dqp_link_partner
`default_nettype wire

// file: verif/dcb_qos_classify_police_test.sv
// Self-checking bench for the port QoS classifier and policer
`timescale 1ns/10ps
`default_nettype none
module dcb_qos_classify_police_test;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, frmValid, frmTagged, frmCtrl, frmEgress;
  logic [2:0] frmPrio, outPrio, outTc, rp;
  logic [5:0] frmDscp, outDscp;
  logic [15:0] frmLen;
  logic outValid, outDrop, outStrict, outPfc;
  logic [1:0] outColor;
  logic [3:0] outGroup;
  logic [7:0] pfcPrioMask;
  logic [41:0] expQ[$], ent;
  logic [20:0] got;
  logic [5:0] gp;
  int badCount = 0, samplesChecked = 0, cycles = 0, seed = 26;

  always #50 core_clk = ~core_clk;

  dqp_qos DUT (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .frmValid, .frmTagged, .frmCtrl, .frmEgress, .frmPrio, .frmDscp,
    .frmLen, .outValid, .outDrop, .outColor, .outPrio, .outDscp, .outTc, .outGroup,
    .outStrict, .outPfc, .pfcPrioMask);

  dqp_link_partner LP (.core_clk, .frmValid, .frmTagged, .frmCtrl, .frmEgress,
    .frmPrio, .frmDscp, .frmLen);

  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] ex);
    samplesChecked++;
    if (seen !== ex) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", s, ex, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_check(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check("register", rd & m, e);
  endtask : reg_check

  // Notes the expected result, then sends one descriptor with a random code point
  task automatic frame(input logic [2:0] k, input logic [2:0] p, input logic [15:0] n,
      input logic [8:0] m, input logic [8:0] e, input logic [5:0] g);
    logic [5:0] ds;
    ds = 6'($random(seed));
    expQ.push_back({m, 12'hFFF, e, g, ds});
    LP.send(k, p, ds, n);
  endtask : frame

  task automatic finishTest();
    $display("checked %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finishTest

  // Result watcher: drop, color, priority, class under the noted mask
  always @(posedge core_clk) begin
    if (outValid === 1'b1) begin
      check("pending", 32'(expQ.size() > 0), 32'h0000_0001);
      ent = expQ.pop_front();
      got = {outDrop, outColor, outPrio, outTc, outGroup, outStrict, outPfc, outDscp};
      check("frame", {11'h000, ent[41:21] & got}, {11'h000, ent[20:0]});
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      badCount++;
      finishTest();
    end
  end

  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 16; i++)
      reg_check(12'h040 + 12'(4 * i), (i < 8) ? 32'h0001_F100 : 32'h0001_F1FF, {15'h0, 1'(i < 8), 4'(i), 3'h0, dqp_pkg::PFC_RST[i], 8'h00});
    check("flow mask", {24'h0, pfcPrioMask}, 32'h0000_0002);
    apb(1'b0, 12'h7F0, 32'h0000_0000);
    check("slave error", {31'h0, err}, 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    rp = 3'($random(seed));
    gp = {1'b1, rp, 1'b0, rp == 3'h1};
    frame(3'h0, rp, 16'h0001, 9'h1C0, 9'h180, gp);
    apb(1'b1, 12'h020, 32'h0000_0064);
    apb(1'b1, 12'h024, 32'h0000_03E8);
    apb(1'b1, 12'h028, 32'h0000_0064);
    apb(1'b1, 12'h02C, 32'h0000_07D0);
    apb(1'b1, 12'h00C, 32'h0001_0005);
    apb(1'b1, 12'h010, 32'h0002_0010);
    repeat (24000) @(posedge core_clk);
    frame(3'h0, rp, 16'h0258, 9'h1FF, {3'h0, rp, 3'h5}, gp);
    frame(3'h0, rp, 16'h0226, 9'h1F8, 9'h050, 6'h28);
    frame(3'h0, rp, 16'h03E8, 9'h1C0, 9'h180, gp);
    frame(3'h1, rp, 16'h0001, 9'h1C0, 9'h180, gp);
    apb(1'b1, 12'h000, 32'h0000_3321);
    frame(3'h4, 3'h7, 16'h0040, 9'h038, 9'h010, 6'h28);
    frame(3'h2, rp, 16'h0040, 9'h1C7, 9'h007, gp);
    repeat (4) @(posedge core_clk);
    reg_check(12'h008, 32'hFFFF_FFFF, 32'h0000_0001);
    apb(1'b1, 12'h100, 32'h0000_0007);
    apb(1'b1, 12'h000, 32'h0000_3329);
    reg_check(12'h004, 32'h0000_0006, 32'h0000_0002);
    apb(1'b1, 12'h048, 32'h0000_0100);
    apb(1'b1, 12'h080, 32'h0000_0009);
    apb(1'b1, 12'h000, 32'h0000_3325);
    reg_check(12'h004, 32'h0000_0001, 32'h0000_0001);
    reg_check(12'h048, 32'h0000_0100, 32'h0000_0000);
    check("flow mask", {24'h0, pfcPrioMask}, 32'h0000_0003);
    check("drained", 32'(expQ.size()), 32'h0000_0000);
    finishTest();
  end
endmodule : dcb_qos_classify_police_test
`default_nettype wire
